// *** design/acr_pkg.sv ***
package acr_pkg;

  // Bus geometry.
  localparam int ACR_ADDR_W = 12;
  localparam int ACR_DATA_W = 32;

  // Register byte offsets.
  localparam logic [11:0] ACR_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] ACR_STATUS_OFFSET = 12'h004;

  // Control word field positions.
  localparam int ACR_DIV_LSB = 10;
  localparam int ACR_ACQ_LSB = 8;
  localparam int ACR_ARM_BIT = 7;
  localparam int ACR_PWR_BIT = 5;
  localparam int ACR_MODE_LSB = 3;
  localparam int ACR_TYPE_LSB = 0;

  // Status word field positions.
  localparam int ACR_ST_BUSY_BIT = 0;
  localparam int ACR_ST_CONT_BIT = 1;
  localparam int ACR_ST_OK_BIT = 2;

  // Reset values of the control word fields.
  localparam logic [15:0] ACR_CTRL_RESET = 16'h0600;
  localparam logic [2:0] ACR_DIV_RESET = 3'h1;
  localparam logic [1:0] ACR_ACQ_RESET = 2'h2;

  // Clock divider codes.
  localparam logic [2:0] ACR_DIV_MAX = 3'h5;
  localparam logic [4:0] ACR_DIV_CAP = 5'h1f;

  // Acquisition length in converter clocks for code zero.
  localparam logic [4:0] ACR_ACQ_BASE = 5'h02;

  // Input configuration codes.
  localparam logic [1:0] ACR_MODE_SINGLE = 2'h0;
  localparam logic [1:0] ACR_MODE_DIFF = 2'h1;
  localparam logic [1:0] ACR_MODE_PSEUDO = 2'h2;
  localparam logic [1:0] ACR_MODE_RSVD = 2'h3;

  // Conversion trigger codes.
  localparam logic [2:0] ACR_TYPE_PIN = 3'h0;
  localparam logic [2:0] ACR_TYPE_TMR1 = 3'h1;
  localparam logic [2:0] ACR_TYPE_TMR0 = 3'h2;
  localparam logic [2:0] ACR_TYPE_SINGLE = 3'h3;
  localparam logic [2:0] ACR_TYPE_CONT = 3'h4;
  localparam logic [2:0] ACR_TYPE_LOGIC = 3'h5;

  // Power-up settling time the software must allow, and its cycle count.
  localparam int ACR_CLK_MHZ = 125;
  localparam int ACR_PWRUP_US = 5;
  localparam int ACR_PWRUP_CYCLES = ACR_PWRUP_US * ACR_CLK_MHZ;

  typedef enum logic [1:0]
  {
    ACR_IDLE = 2'b01,
    ACR_BUSY = 2'b10
  } acr_fsm_type;

endpackage : acr_pkg

// *** design/acr_div_if.sv ***
`timescale 1ns/10ps
interface acr_div_if;
  logic [2:0] div_code;
  logic tick;
  modport ctl (output div_code, input tick);
  modport div (input div_code, output tick);
endinterface : acr_div_if

// *** design/acr_clk_div.sv ***
`timescale 1ns/10ps
module acr_clk_div #(
  parameter int CNT_W = 5 // Width of the divide counter.
) (
  input wire logic clk, // System clock.
  input wire logic reset, // Asynchronous reset, active high.
  acr_div_if.div dv // Divider code in, converter clock tick out.
);
  import acr_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } acr_div_state_type;

  acr_div_state_type st_reg;
  acr_div_state_type st_next;
  logic [CNT_W-1:0] limit;

  always_comb
  begin
    // Codes above the largest divider hold the slowest rate.
    if (dv.div_code > ACR_DIV_MAX)
    begin
      limit = CNT_W'(ACR_DIV_CAP);
    end
    else
    begin
      limit = CNT_W'((1 << dv.div_code) - 1);
    end
    st_next = st_reg;
    if (st_reg.cnt >= limit)
    begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + CNT_W'(1);
      st_next.tick = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign dv.tick = st_reg.tick;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_div_bypass;
    (dv.div_code == 3'h0) [*2] |=> dv.tick;
  endproperty
  a_div_bypass: assert property (p_div_bypass) else $error("Undivided clock missed a tick.");

  property p_div_by_two;
    (dv.div_code == ACR_DIV_RESET) [*3] ##0 dv.tick |=> !dv.tick ##1 dv.tick;
  endproperty
  a_div_by_two: assert property (p_div_by_two) else $error("Divide by two period wrong.");

endmodule : acr_clk_div

// *** design/acr_top.sv ***
`timescale 1ns/10ps
// What this block does
// - The converter clock is the source clock divided by 2, 4, 8, 16 or 32 per codes 001-101, 001 at reset.
// - Divider code 000 passes the source clock rate through undivided.
// - The acquisition code selects 2, 4, 8 or 16 converter clocks, 8 at reset.
// - Triggered starts are taken only while the start-enable bit 7 is set; clearing it disarms them.
// - Clearing start-enable does not stop a running continuous conversion sequence.
// - Power bit 5 set keeps the converter in normal mode, cleared puts it in power-down.
// - Mode bits 4:3 select single-ended 00, differential 01, pseudo differential 10; 11 is reserved.
// - Conversion type 000 starts conversions on the external trigger pin.
// - Type 001 starts on the second general timer and type 010 on the first general timer.
// - Type 011 runs one software conversion and the type field returns to 000 when it completes.
// - Type 100 converts continuously under software and type 101 starts on the logic array trigger.
module acr_top (
  input wire logic clk, // System clock, 125 MHz.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB write direction.
  input wire logic [acr_pkg::ACR_ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [acr_pkg::ACR_DATA_W-1:0] pwdata, // APB write data.
  output logic [acr_pkg::ACR_DATA_W-1:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic external_trigger_pin, // Asynchronous start pin.
  input wire logic second_general_timer, // Timer start pulse.
  input wire logic first_general_timer, // Timer start pulse.
  input wire logic programmable_logic_array, // Logic array start pulse.
  input wire logic conv_done, // Converter reports end of conversion.
  output logic conv_start, // One-cycle start pulse to converter.
  output logic conv_busy, // Conversion in progress.
  output logic adc_power, // Converter in normal mode when high.
  output logic [1:0] input_mode, // Input configuration.
  output logic [4:0] acq_clocks, // Acquisition length in converter clocks.
  output logic adc_clk_tick // Converter clock enable tick.
);
  import acr_pkg::*;

  typedef struct packed {
    logic [2:0] clk_div;
    logic [1:0] acq;
    logic arm;
    logic power;
    logic [1:0] mode;
    logic [2:0] ctype;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    acr_fsm_type fsm;
    logic cont_run;
    logic start;
    logic [4:0] acq_cnt;
    logic [ACR_DATA_W-1:0] rdata;
  } acr_ctl_state_type;

  acr_ctl_state_type st_reg;
  acr_ctl_state_type st_next;
  logic wr_ctrl;
  logic rd_sel;
  logic mapped;
  logic cfg_ok;
  logic pin_edge;
  logic trig;
  logic [15:0] ctrl_word;
  logic [ACR_DATA_W-1:0] status_word;

  acr_div_if div_bus ();

  acr_clk_div #(
    .CNT_W(5)
  ) u_div (
    .clk(clk),
    .reset(reset),
    .dv(div_bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus decode.

  assign mapped = (paddr == ACR_CTRL_OFFSET) || (paddr == ACR_STATUS_OFFSET);
  assign wr_ctrl = psel && penable && pwrite && (paddr == ACR_CTRL_OFFSET);
  assign rd_sel = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[ACR_DIV_LSB +: 3] = st_reg.clk_div;
    ctrl_word[ACR_ACQ_LSB +: 2] = st_reg.acq;
    ctrl_word[ACR_ARM_BIT] = st_reg.arm;
    ctrl_word[ACR_PWR_BIT] = st_reg.power;
    ctrl_word[ACR_MODE_LSB +: 2] = st_reg.mode;
    ctrl_word[ACR_TYPE_LSB +: 3] = st_reg.ctype;
    status_word = '0;
    status_word[ACR_ST_BUSY_BIT] = (st_reg.fsm == ACR_BUSY);
    status_word[ACR_ST_CONT_BIT] = st_reg.cont_run;
    status_word[ACR_ST_OK_BIT] = cfg_ok;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger selection.

  // A start needs power and a legal mode and type; otherwise the converter stays idle.
  assign cfg_ok = st_reg.power && (st_reg.mode != ACR_MODE_RSVD)
    && (st_reg.ctype <= ACR_TYPE_LOGIC);
  assign pin_edge = st_reg.pin_sync && !st_reg.pin_prev;

  always_comb
  begin
    case (st_reg.ctype)
      ACR_TYPE_PIN: trig = pin_edge;
      ACR_TYPE_TMR1: trig = second_general_timer;
      ACR_TYPE_TMR0: trig = first_general_timer;
      ACR_TYPE_SINGLE: trig = 1'b1;
      ACR_TYPE_CONT: trig = 1'b1;
      ACR_TYPE_LOGIC: trig = programmable_logic_array;
      default: trig = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    st_next = st_reg;
    st_next.pin_meta = external_trigger_pin;
    st_next.pin_sync = st_reg.pin_meta;
    st_next.pin_prev = st_reg.pin_sync;
    st_next.start = 1'b0;
    st_next.rdata = '0;
    if (rd_sel && (paddr == ACR_CTRL_OFFSET))
    begin
      st_next.rdata = ACR_DATA_W'(ctrl_word);
    end
    else if (rd_sel && (paddr == ACR_STATUS_OFFSET))
    begin
      st_next.rdata = status_word;
    end
    if (wr_ctrl)
    begin
      st_next.clk_div = pwdata[ACR_DIV_LSB +: 3];
      st_next.acq = pwdata[ACR_ACQ_LSB +: 2];
      st_next.arm = pwdata[ACR_ARM_BIT];
      st_next.power = pwdata[ACR_PWR_BIT];
      st_next.mode = pwdata[ACR_MODE_LSB +: 2];
      st_next.ctype = pwdata[ACR_TYPE_LSB +: 3];
    end
    // Continuous running survives a cleared arm bit, but not a type change or power-down.
    st_next.cont_run = cfg_ok && (st_reg.ctype == ACR_TYPE_CONT)
      && (st_reg.cont_run || st_reg.arm);
    case (st_reg.fsm)
      ACR_IDLE:
      begin
        if (cfg_ok && trig && (st_reg.arm || st_reg.cont_run))
        begin
          st_next.start = 1'b1;
          st_next.fsm = ACR_BUSY;
        end
      end
      ACR_BUSY:
      begin
        if (!st_reg.power)
        begin
          st_next.fsm = ACR_IDLE;
        end
        else if (conv_done)
        begin
          st_next.fsm = ACR_IDLE;
          // The hardware fallback wins over a same-cycle software write of the type.
          if (st_reg.ctype == ACR_TYPE_SINGLE)
          begin
            st_next.ctype = ACR_TYPE_PIN;
          end
        end
      end
      default: st_next.fsm = ACR_IDLE;
    endcase
    st_next.acq_cnt = 5'(ACR_ACQ_BASE << st_next.acq);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_reg <= '0;
      st_reg.clk_div <= ACR_DIV_RESET;
      st_reg.acq <= ACR_ACQ_RESET;
      st_reg.fsm <= ACR_IDLE;
      st_reg.acq_cnt <= 5'(ACR_ACQ_BASE << ACR_ACQ_RESET);
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign div_bus.div_code = st_reg.clk_div;
  assign adc_clk_tick = div_bus.tick;
  assign prdata = st_reg.rdata;
  assign conv_start = st_reg.start;
  assign conv_busy = (st_reg.fsm == ACR_BUSY);
  assign adc_power = st_reg.power;
  assign input_mode = st_reg.mode;
  assign acq_clocks = st_reg.acq_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_ctrl_write;
    psel && penable && pwrite && (paddr == ACR_CTRL_OFFSET);
  endsequence

  sequence s_single_done;
    conv_busy && conv_done && adc_power && (st_reg.ctype == ACR_TYPE_SINGLE);
  endsequence

  sequence s_idle_ready;
    !conv_busy && cfg_ok && st_reg.arm;
  endsequence

  property p_start_armed;
    conv_start |-> $past(st_reg.arm) || $past(st_reg.cont_run);
  endproperty
  a_start_armed: assert property (p_start_armed) else $error("Start without arming.");

  property p_cont_survives;
    st_reg.cont_run && cfg_ok && (st_reg.ctype == ACR_TYPE_CONT) && !st_reg.arm
      |=> st_reg.cont_run;
  endproperty
  a_cont_survives: assert property (p_cont_survives) else $error("Continuous run dropped.");

  property p_single_fallback;
    s_single_done |=> (st_reg.ctype == ACR_TYPE_PIN) && !conv_busy;
  endproperty
  a_single_fallback: assert property (p_single_fallback) else $error("Type not returned.");

  property p_power_down;
    s_ctrl_write ##0 !pwdata[ACR_PWR_BIT] |=> !adc_power ##1 !conv_start;
  endproperty
  a_power_down: assert property (p_power_down) else $error("Power bit not applied.");

  property p_reserved_block;
    (st_reg.mode == ACR_MODE_RSVD) || (st_reg.ctype > ACR_TYPE_LOGIC) |=> !conv_start;
  endproperty
  a_reserved_block: assert property (p_reserved_block) else $error("Start on bad code.");

  property p_pin_start;
    s_idle_ready ##0 (st_reg.ctype == ACR_TYPE_PIN) && pin_edge |=> conv_start ##1 conv_busy;
  endproperty
  a_pin_start: assert property (p_pin_start) else $error("Pin edge not taken.");

  property p_timer_start;
    s_idle_ready ##0 (st_reg.ctype == ACR_TYPE_TMR1) && second_general_timer |=> conv_start;
  endproperty
  a_timer_start: assert property (p_timer_start) else $error("Timer start missed.");

  property p_logic_start;
    s_idle_ready ##0 (st_reg.ctype == ACR_TYPE_LOGIC) && programmable_logic_array |=> conv_start;
  endproperty
  a_logic_start: assert property (p_logic_start) else $error("Logic array start missed.");

  property p_acq_len;
    s_ctrl_write ##0 (pwdata[ACR_ACQ_LSB +: 2] == 2'h3) |=> (acq_clocks == 5'h10);
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("Acquisition length wrong.");

  property p_mode_out;
    s_ctrl_write ##0 (pwdata[ACR_MODE_LSB +: 2] == ACR_MODE_PSEUDO)
      |=> (input_mode == ACR_MODE_PSEUDO);
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("Mode not applied.");

endmodule : acr_top

// *** verification/acr_conv_model.sv ***
`timescale 1ns/10ps
module acr_conv_model #(
  parameter int DLY = 5 // Conversion length in system clocks.
) (
  input wire logic clk, // System clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic conv_start, // Start pulse from the control block.
  output logic conv_done // End of conversion pulse.
);
  int cnt;

  // A start that arrives during a conversion restarts the count, as the real
  // converter would only ever see one start per conversion.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt <= 0;
      conv_done <= 1'b0;
    end
    else
    begin
      conv_done <= 1'b0;
      if (conv_start)
        cnt <= DLY;
      else if (cnt == 1)
      begin
        conv_done <= 1'b1;
        cnt <= 0;
      end
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule : acr_conv_model

// *** verification/adc_control_register_tb.sv ***
`timescale 1ns/10ps
module adc_control_register_tb;
  import acr_pkg::*;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] trig;
  logic conv_done, conv_start, conv_busy, adc_power, adc_clk_tick;
  logic [1:0] input_mode;
  logic [4:0] acq_clocks;
  int n_mismatch, compares, starts, cycles, s0;
  int trg_type[4] = '{0, 1, 2, 5};

  acr_top u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_trigger_pin(trig[0]), .second_general_timer(trig[1]),
    .first_general_timer(trig[2]), .programmable_logic_array(trig[3]),
    .conv_done(conv_done), .conv_start(conv_start), .conv_busy(conv_busy),
    .adc_power(adc_power), .input_mode(input_mode), .acq_clocks(acq_clocks),
    .adc_clk_tick(adc_clk_tick));

  acr_conv_model #(.DLY(5)) u_conv (.clk(clk), .reset(reset), .conv_start(conv_start),
    .conv_done(conv_done));

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (conv_start === 1'b1)
      starts++;
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  // Waits on pready rather than assuming the zero-wait answer.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulse(input int idx);
    @(posedge clk);
    trig[idx] <= 1'b1;
    @(posedge clk);
    trig[idx] <= 1'b0;
    repeat (30) @(posedge clk);
  endtask : pulse

  task automatic tick_gap(output int n);
    // Ticks seen in the first two edges after a divider write may start from a count left by the old code.
    repeat (2) @(posedge clk);
    n = 0;
    while (adc_clk_tick !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (adc_clk_tick !== 1'b1 && n < 200);
  endtask : tick_gap

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    reset <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    trig <= 4'h0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, ACR_CTRL_OFFSET, 32'h0000_0000);
    chk(rd, 32'h0000_0600);
    chk(32'(acq_clocks), 32'h0000_0008);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, ACR_CTRL_OFFSET, 32'((i << 10) | ((i & 3) << 8) | ((i & 1) << 5) | ((i & 3) << 3)));
      tick_gap(n);
      chk(32'(n), 32'(1 << i));
      chk(32'(acq_clocks), 32'(2 << (i & 3)));
      chk(32'(adc_power), 32'(i & 1));
      chk(32'(input_mode), 32'(i & 3));
    end
    repeat (ACR_PWRUP_CYCLES) @(posedge clk);
    // Each trigger source: ignored unarmed, ignored when another source fires.
    foreach (trg_type[k])
    begin
      s0 = starts;
      apb(1'b1, ACR_CTRL_OFFSET, 32'h0000_0620 | 32'(trg_type[k]));
      pulse(k);
      chk(32'(starts), 32'(s0));
      apb(1'b1, ACR_CTRL_OFFSET, 32'h0000_06a0 | 32'(trg_type[k]));
      for (int j = 0; j < 4; j++)
        if (j != k)
          pulse(j);
      chk(32'(starts), 32'(s0));
      pulse(k);
      chk(32'(starts), 32'(s0 + 1));
    end
    s0 = starts;
    apb(1'b1, ACR_CTRL_OFFSET, 32'h0000_06b9);
    pulse(1);
    apb(1'b1, ACR_CTRL_OFFSET, 32'h0000_06a6);
    for (int j = 0; j < 4; j++)
      pulse(j);
    chk(32'(starts), 32'(s0));
    apb(1'b1, ACR_CTRL_OFFSET, 32'h0000_06a3);
    repeat (30) @(posedge clk);
    // Read before software touches the type, so only the hardware fallback can clear it.
    apb(1'b0, ACR_CTRL_OFFSET, 32'h0000_0000);
    chk(rd & 32'h0000_00a7, 32'h0000_00a0);
    apb(1'b1, ACR_CTRL_OFFSET, 32'h0000_0620);
    chk(32'(starts), 32'(s0 + 1));
    apb(1'b0, ACR_CTRL_OFFSET, 32'h0000_0000);
    chk(rd & 32'h0000_0087, 32'h0000_0000);
    apb(1'b1, ACR_CTRL_OFFSET, 32'h0000_06a4);
    repeat (40) @(posedge clk);
    apb(1'b1, ACR_CTRL_OFFSET, 32'h0000_0624);
    s0 = starts;
    repeat (40) @(posedge clk);
    chk(32'(starts > s0 + 2), 32'h0000_0001);
    apb(1'b0, ACR_STATUS_OFFSET, 32'h0000_0000);
    chk(rd & 32'h0000_0006, 32'h0000_0006);
    apb(1'b1, ACR_CTRL_OFFSET, 32'h0000_0600);
    // The write lands on the edge the task returns on, and idle follows one edge later.
    repeat (2) @(posedge clk);
    chk(32'(adc_power), 32'h0000_0000);
    chk(32'(conv_busy), 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    complete_run();
  end
endmodule : adc_control_register_tb
